// File: rtl/ivc_classifier.sv
// Ingress VLAN classifier with private-group forwarding mask and APB tables.
// Assumes frame headers from port receive logic on pclk; the forwarding engine drains results.
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module ivc_classifier #(
	parameter int NPORT = 10,
	parameter int PW = 4,
	parameter int N_PG = 8,
	parameter int N_VMEM = 16,
	parameter int N_MAC = 8,
	parameter int N_PROTO = 8,
	parameter int N_GRP = 8,
	parameter int N_SUB = 8
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ivc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Frame header in
	input wire logic frm_valid,
	output logic frm_ready,
	input wire logic [PW-1:0] frm_port,
	input wire logic frm_tagged,
	input wire logic [ivc_pkg::VID_W-1:0] frm_tag_vid,
	input wire logic [47:0] frm_smac,
	input wire ivc_pkg::ivc_fmt_e frm_fmt,
	input wire logic [15:0] frm_type,
	input wire logic [23:0] frm_oui,
	input wire logic frm_ip_valid,
	input wire logic [31:0] frm_sip,
	// Classification out
	output logic cls_valid,
	input wire logic cls_ready,
	output logic [PW-1:0] cls_port,
	output logic [ivc_pkg::VID_W-1:0] cls_vid,
	output ivc_pkg::ivc_src_e cls_src,
	output logic [NPORT-1:0] cls_fwd_mask
);
	import ivc_pkg::*;
	localparam int DW = PW + VID_W + 3 + NPORT;

	logic [2:0] ctrl_reg;
	logic [NPORT-1:0] iso_reg;
	logic [31:0] count_reg;
	logic [VID_W-1:0] port_default_vlan_reg [NPORT];
	logic [NPORT-1:0] pg_reg [N_PG];
	logic vm_valid_reg [N_VMEM];
	logic [VID_W-1:0] vm_vid_reg [N_VMEM];
	logic [NPORT-1:0] vm_mask_reg [N_VMEM];
	logic mac_valid_reg [N_MAC];
	logic [47:0] mac_addr_reg [N_MAC];
	logic [VID_W-1:0] mac_vid_reg [N_MAC];
	logic [NPORT-1:0] mac_mask_reg [N_MAC];
	logic pr_valid_reg [N_PROTO];
	ivc_fmt_e pr_fmt_reg [N_PROTO];
	logic [GRP_W-1:0] pr_grp_reg [N_PROTO];
	logic [15:0] pr_val_reg [N_PROTO];
	logic [23:0] pr_oui_reg [N_PROTO];
	logic [NPORT-1:0] pr_mask_reg [N_PROTO];
	logic grp_valid_reg [N_GRP];
	logic [VID_W-1:0] grp_vid_reg [N_GRP];
	logic sub_valid_reg [N_SUB];
	logic [31:0] sub_ip_reg [N_SUB];
	logic [5:0] sub_len_reg [N_SUB];
	logic [VID_W-1:0] sub_vid_reg [N_SUB];
	logic [NPORT-1:0] sub_mask_reg [N_SUB];

	// APB decode
	logic [3:0] tbl;
	logic [3:0] ent;
	logic [1:0] wrd;
	logic err_c;
	logic [31:0] rdata_c;
	logic wr_en;
	logic [47:0] mac_cand;
	logic [15:0] pr_cand;
	ivc_fmt_e pr_fmt_cand;

	assign tbl = paddr[11:8];
	assign ent = paddr[7:4];
	assign wrd = paddr[3:2];
	assign wr_en = psel & penable & pready & pwrite & ~err_c;
	assign pr_fmt_cand = ivc_fmt_e'(pwdata[PR_FMT_LSB +: 2]);
	assign pr_cand = pwdata[15:0];

	always_comb begin
		mac_cand = (wrd == 2'h0) ? {mac_addr_reg[ent[2:0]][47:32], pwdata} : {pwdata[15:0], mac_addr_reg[ent[2:0]][31:0]};
		rdata_c = '0;
		err_c = 1'b0;
		unique case (tbl)
			TBL_GLOBAL: begin
				if (ent == GLB_CTRL && wrd == 2'h0) begin
					rdata_c = {29'h0, ctrl_reg};
				end else if (ent == GLB_ISO && wrd == 2'h0) begin
					rdata_c[NPORT-1:0] = iso_reg;
				end else if (ent == GLB_COUNT && wrd == 2'h0 && !pwrite) begin
					rdata_c = count_reg;
				end else begin
					err_c = 1'b1;
				end
			end
			TBL_PORT_DEFAULT_VLAN: begin
				err_c = (32'(ent) >= NPORT) || wrd != 2'h0;
				rdata_c[VID_W-1:0] = port_default_vlan_reg[ent];
			end
			TBL_PGRP: begin
				err_c = (32'(ent) >= N_PG) || wrd != 2'h0;
				rdata_c[NPORT-1:0] = pg_reg[ent[2:0]];
			end
			TBL_VMEM: begin
				err_c = wrd > 2'h1;
				rdata_c = wrd[0] ? 32'(vm_mask_reg[ent]) : {vm_valid_reg[ent], 19'h0, vm_vid_reg[ent]};
			end
			TBL_MAC: begin
				err_c = (32'(ent) >= N_MAC) || wrd == 2'h3;
				unique case (wrd)
					2'h0: rdata_c = mac_addr_reg[ent[2:0]][31:0];
					2'h1: rdata_c = {mac_valid_reg[ent[2:0]], 3'h0, mac_vid_reg[ent[2:0]], mac_addr_reg[ent[2:0]][47:32]};
					default: rdata_c = 32'(mac_mask_reg[ent[2:0]]);
				endcase
				// Refuse a second entry for an address already held
				if (pwrite && wrd != 2'h2 && (mac_valid_reg[ent[2:0]] || (wrd == 2'h1 && pwdata[VALID_BIT]))) begin
					for (int i = 0; i < N_MAC; i++) begin
						if (i != 32'(ent) && mac_valid_reg[i] && mac_addr_reg[i] == mac_cand) begin
							err_c = 1'b1; // [RULE_05]
						end
					end
				end
			end
			TBL_PROTO: begin
				err_c = (32'(ent) >= N_PROTO) || wrd == 2'h3;
				unique case (wrd)
					2'h0: rdata_c = {pr_valid_reg[ent[2:0]], 5'h0, pr_fmt_reg[ent[2:0]], 5'h0,
						pr_grp_reg[ent[2:0]], pr_val_reg[ent[2:0]]};
					2'h1: rdata_c = {8'h00, pr_oui_reg[ent[2:0]]};
					default: rdata_c = 32'(pr_mask_reg[ent[2:0]]);
				endcase
				if (pwrite && wrd == 2'h0) begin
					if (pwdata[PR_FMT_LSB +: 2] == 2'h3) begin
						err_c = 1'b1; // [RULE_07]
					end
					if (pr_fmt_cand == IVC_FMT_ETH && pr_cand < ETYPE_MIN) begin
						err_c = 1'b1; // [RULE_08]
					end
					if (pr_fmt_cand == IVC_FMT_SNAP && pr_oui_reg[ent[2:0]] == 24'h00_0000 && pr_cand < ETYPE_MIN) begin
						err_c = 1'b1; // [RULE_09]
					end
				end
			end
			TBL_GRP: begin
				err_c = (32'(ent) >= N_GRP) || wrd != 2'h0;
				rdata_c = {grp_valid_reg[ent[2:0]], 19'h0, grp_vid_reg[ent[2:0]]};
			end
			TBL_SUB: begin
				err_c = (32'(ent) >= N_SUB) || wrd == 2'h3;
				unique case (wrd)
					2'h0: rdata_c = sub_ip_reg[ent[2:0]];
					2'h1: rdata_c = {sub_valid_reg[ent[2:0]], 9'h0, sub_len_reg[ent[2:0]], 4'h0, sub_vid_reg[ent[2:0]]};
					default: rdata_c = 32'(sub_mask_reg[ent[2:0]]);
				endcase
				if (pwrite && wrd == 2'h1 && pwdata[SUB_LEN_LSB +: 6] > SUB_LEN_MAX) begin
					err_c = 1'b1; // [RULE_15]
				end
			end
			default: err_c = 1'b1;
		endcase
	end

	// One wait state; the access completes on the second access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & err_c;
			prdata <= (psel && penable && !pready && !pwrite && !err_c) ? rdata_c : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= CTRL_RST;
			iso_reg <= '0; // [RULE_02]
		end else if (wr_en && tbl == TBL_GLOBAL) begin
			if (ent == GLB_CTRL) begin
				ctrl_reg <= pwdata[2:0];
			end
			if (ent == GLB_ISO) begin
				iso_reg <= pwdata[NPORT-1:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NPORT; i++) begin
				port_default_vlan_reg[i] <= PORT_DEFAULT_VLAN_RST;
			end
			for (int i = 0; i < N_PG; i++) begin
				pg_reg[i] <= (i == 0) ? '1 : '0;
			end
		end else if (wr_en && tbl == TBL_PORT_DEFAULT_VLAN) begin
			port_default_vlan_reg[ent] <= pwdata[VID_W-1:0];
		end else if (wr_en && tbl == TBL_PGRP) begin
			pg_reg[ent[2:0]] <= pwdata[NPORT-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < N_VMEM; i++) begin
				vm_valid_reg[i] <= 1'b0;
				vm_vid_reg[i] <= PORT_DEFAULT_VLAN_RST;
				vm_mask_reg[i] <= '0;
			end
		end else if (wr_en && tbl == TBL_VMEM) begin
			if (wrd == 2'h0) begin
				vm_valid_reg[ent] <= pwdata[VALID_BIT];
				vm_vid_reg[ent] <= pwdata[VID_W-1:0];
			end else begin
				vm_mask_reg[ent] <= pwdata[NPORT-1:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < N_MAC; i++) begin
				mac_valid_reg[i] <= 1'b0;
				mac_addr_reg[i] <= '0;
				mac_vid_reg[i] <= PORT_DEFAULT_VLAN_RST;
				mac_mask_reg[i] <= '0;
			end
		end else if (wr_en && tbl == TBL_MAC) begin
			unique case (wrd)
				2'h0: mac_addr_reg[ent[2:0]][31:0] <= pwdata;
				2'h1: begin
					mac_valid_reg[ent[2:0]] <= pwdata[VALID_BIT];
					mac_vid_reg[ent[2:0]] <= pwdata[HI_VID_LSB +: VID_W];
					mac_addr_reg[ent[2:0]][47:32] <= pwdata[15:0];
				end
				default: mac_mask_reg[ent[2:0]] <= pwdata[NPORT-1:0];
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < N_PROTO; i++) begin
				pr_valid_reg[i] <= 1'b0;
				pr_fmt_reg[i] <= IVC_FMT_ETH;
				pr_grp_reg[i] <= '0;
				pr_val_reg[i] <= ETYPE_RST; // [RULE_08]
				pr_oui_reg[i] <= '0;
				pr_mask_reg[i] <= '0;
			end
		end else if (wr_en && tbl == TBL_PROTO) begin
			unique case (wrd)
				2'h0: begin
					pr_valid_reg[ent[2:0]] <= pwdata[VALID_BIT];
					pr_fmt_reg[ent[2:0]] <= pr_fmt_cand;
					pr_grp_reg[ent[2:0]] <= pwdata[PR_GRP_LSB +: GRP_W];
					// A change to LLC format without a value loads the LLC default
					if (pr_fmt_cand == IVC_FMT_LLC && pr_fmt_reg[ent[2:0]] != IVC_FMT_LLC && pr_cand == 16'h0000) begin
						pr_val_reg[ent[2:0]] <= LLC_RST; // [RULE_11]
					end else begin
						pr_val_reg[ent[2:0]] <= pr_cand; // [RULE_10]
					end
				end
				2'h1: pr_oui_reg[ent[2:0]] <= pwdata[23:0];
				default: pr_mask_reg[ent[2:0]] <= pwdata[NPORT-1:0];
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < N_GRP; i++) begin
				grp_valid_reg[i] <= 1'b0;
				grp_vid_reg[i] <= PORT_DEFAULT_VLAN_RST;
			end
		end else if (wr_en && tbl == TBL_GRP) begin
			grp_valid_reg[ent[2:0]] <= pwdata[VALID_BIT];
			grp_vid_reg[ent[2:0]] <= pwdata[VID_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < N_SUB; i++) begin
				sub_valid_reg[i] <= 1'b0;
				sub_ip_reg[i] <= '0;
				sub_len_reg[i] <= '0;
				sub_vid_reg[i] <= PORT_DEFAULT_VLAN_RST;
				sub_mask_reg[i] <= '0;
			end
		end else if (wr_en && tbl == TBL_SUB) begin
			unique case (wrd)
				2'h0: sub_ip_reg[ent[2:0]] <= pwdata;
				2'h1: begin
					sub_valid_reg[ent[2:0]] <= pwdata[VALID_BIT];
					sub_len_reg[ent[2:0]] <= pwdata[SUB_LEN_LSB +: 6];
					sub_vid_reg[ent[2:0]] <= pwdata[VID_W-1:0];
				end
				default: sub_mask_reg[ent[2:0]] <= pwdata[NPORT-1:0];
			endcase
		end
	end

	// Classification
	logic [NPORT-1:0] src_bit;
	logic mac_hit, pr_hit, sub_hit;
	logic [VID_W-1:0] mac_vid, pr_vid, sub_vid, vid_c;
	ivc_src_e src_c;
	logic [NPORT-1:0] vmask_c, pg_union_c, fwd_c;
	logic push_ready;

	assign src_bit = NPORT'(1) << frm_port;

	always_comb begin
		mac_hit = 1'b0;
		mac_vid = '0;
		pr_hit = 1'b0;
		pr_vid = '0;
		sub_hit = 1'b0;
		sub_vid = '0;
		for (int i = N_MAC - 1; i >= 0; i--) begin
			if (mac_valid_reg[i] && mac_addr_reg[i] == frm_smac && |(mac_mask_reg[i] & src_bit)) begin // [RULE_18]
				mac_hit = ctrl_reg[CTRL_MAC_EN];
				mac_vid = mac_vid_reg[i]; // [RULE_03]
			end
		end
		for (int i = N_PROTO - 1; i >= 0; i--) begin
			if (pr_valid_reg[i] && pr_fmt_reg[i] == frm_fmt && pr_val_reg[i] == frm_type // [RULE_06] [RULE_11]
				&& (pr_fmt_reg[i] != IVC_FMT_SNAP || pr_oui_reg[i] == frm_oui) // [RULE_09]
				&& |(pr_mask_reg[i] & src_bit) && grp_valid_reg[pr_grp_reg[i]]) begin // [RULE_18]
				pr_hit = ctrl_reg[CTRL_PROTO_EN];
				pr_vid = grp_vid_reg[pr_grp_reg[i]]; // [RULE_12]
			end
		end
		for (int i = N_SUB - 1; i >= 0; i--) begin
			if (sub_valid_reg[i] && frm_ip_valid && |(sub_mask_reg[i] & src_bit) // [RULE_18]
				&& ((sub_ip_reg[i] ^ frm_sip) & ~(32'hffff_ffff >> sub_len_reg[i])) == 32'h0000_0000) begin // [RULE_15]
				sub_hit = ctrl_reg[CTRL_SUB_EN];
				sub_vid = sub_vid_reg[i]; // [RULE_13]
			end
		end
	end

	always_comb begin
		if (frm_tagged) begin
			vid_c = frm_tag_vid; // [RULE_17]
			src_c = IVC_SRC_TAG;
		end else if (mac_hit) begin
			vid_c = mac_vid; // [RULE_03]
			src_c = IVC_SRC_MAC;
		end else if (pr_hit) begin
			vid_c = pr_vid; // [RULE_06]
			src_c = IVC_SRC_PROTO;
		end else if (sub_hit) begin
			vid_c = sub_vid; // [RULE_13]
			src_c = IVC_SRC_SUBNET;
		end else begin
			vid_c = port_default_vlan_reg[frm_port]; // [RULE_04] [RULE_14]
			src_c = IVC_SRC_DEFAULT;
		end
	end

	always_comb begin
		vmask_c = '0;
		pg_union_c = '0;
		for (int i = 0; i < N_VMEM; i++) begin
			if (vm_valid_reg[i] && vm_vid_reg[i] == vid_c) begin
				vmask_c = vmask_c | vm_mask_reg[i];
			end
		end
		for (int g = 0; g < N_PG; g++) begin
			if (|(pg_reg[g] & src_bit)) begin
				pg_union_c = pg_union_c | pg_reg[g];
			end
		end
		fwd_c = vmask_c & pg_union_c & ~src_bit; // [RULE_16]
		if (|(iso_reg & src_bit)) begin
			fwd_c = fwd_c & ~iso_reg; // [RULE_01]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= '0;
		end else if (frm_valid && push_ready) begin
			count_reg <= count_reg + 32'h0000_0001;
		end
	end

	logic [2:0] cls_src_bits;
	assign cls_src = ivc_src_e'(cls_src_bits);
	assign frm_ready = push_ready;

	ivc_buf #(
		.W(DW)
	) u_buf (
		.clk(pclk),
		.rstn(presetn),
		.in_valid(frm_valid),
		.in_ready(push_ready),
		.in_data({frm_port, vid_c, 3'(src_c), fwd_c}),
		.out_valid(cls_valid),
		.out_ready(cls_ready),
		.out_data({cls_port, cls_vid, cls_src_bits, cls_fwd_mask})
	);
endmodule : ivc_classifier

// File: rtl/ivc_pkg.sv
// Constants, register map and types of the ingress VLAN classifier.
// Assumes an APB master on the switch core clock drives the register map.
// Notes on behaviour
// RULE_01: Isolated port never forwards to another isolated port in a shared private group.
// RULE_02: Reset clears isolation on every port.
// RULE_03: Untagged frame's source MAC is looked up; a hit assigns that entry's VLAN.
// RULE_04: Source MAC miss falls back to the receiving port's default VLAN.
// RULE_05: One source MAC maps to at most one VLAN; duplicate entries are refused.
// RULE_06: Protocol classification picks the VLAN from the frame's protocol type.
// RULE_07: Each protocol entry selects Ethernet type, SNAP or LLC format.
// RULE_08: Ethernet entries match a type from 0x0600 upward; new entries start at 0x0800.
// RULE_09: SNAP entries match OUI and PID; zero OUI limits PID to 0x0600 upward.
// RULE_10: SNAP entries with nonzero OUI accept any 16-bit PID.
// RULE_11: LLC entries match DSAP and SSAP octets, each defaulting to 0xff.
// RULE_12: Protocol entries resolve to a VLAN through a group table.
// RULE_13: With subnet lookup enabled, a source IP hit assigns the entry's VLAN.
// RULE_14: Subnet miss falls back to the receiving port's default VLAN.
// RULE_15: Subnet entries compare only the leading bits counted by the mask length.
// RULE_16: Forward only to ports in both the frame's VLAN and a shared private group.
// RULE_17: Tagged frames skip all lookups and keep their tag's VLAN.
// RULE_18: A table hit counts only when the receiving port is in the entry's members.
package ivc_pkg;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned VID_W = 12;
	localparam int unsigned GRP_W = 3;
	// Table select in address bits 11:8, entry in 7:4, word in 3:2
	localparam logic [3:0] TBL_GLOBAL = 4'h0;
	localparam logic [3:0] TBL_PORT_DEFAULT_VLAN = 4'h1;
	localparam logic [3:0] TBL_PGRP = 4'h2;
	localparam logic [3:0] TBL_VMEM = 4'h3;
	localparam logic [3:0] TBL_MAC = 4'h4;
	localparam logic [3:0] TBL_PROTO = 4'h5;
	localparam logic [3:0] TBL_GRP = 4'h6;
	localparam logic [3:0] TBL_SUB = 4'h7;
	localparam logic [3:0] GLB_CTRL = 4'h0;
	localparam logic [3:0] GLB_ISO = 4'h1;
	localparam logic [3:0] GLB_COUNT = 4'h2;
	// Field positions
	localparam int unsigned CTRL_MAC_EN = 0;
	localparam int unsigned CTRL_PROTO_EN = 1;
	localparam int unsigned CTRL_SUB_EN = 2;
	localparam int unsigned VALID_BIT = 31;
	localparam int unsigned HI_VID_LSB = 16;
	localparam int unsigned PR_GRP_LSB = 16;
	localparam int unsigned PR_FMT_LSB = 24;
	localparam int unsigned SUB_LEN_LSB = 16;
	// Reset and range values
	localparam logic [2:0] CTRL_RST = 3'h7;
	localparam logic [VID_W-1:0] PORT_DEFAULT_VLAN_RST = 12'h001;
	localparam logic [15:0] ETYPE_RST = 16'h0800;
	localparam logic [15:0] ETYPE_MIN = 16'h0600;
	localparam logic [15:0] LLC_RST = 16'hffff;
	localparam logic [5:0] SUB_LEN_MAX = 6'h20;
	typedef enum logic [1:0] {IVC_FMT_ETH, IVC_FMT_SNAP, IVC_FMT_LLC} ivc_fmt_e;
	typedef enum logic [2:0] {IVC_SRC_TAG, IVC_SRC_MAC, IVC_SRC_PROTO, IVC_SRC_SUBNET, IVC_SRC_DEFAULT} ivc_src_e;
endpackage : ivc_pkg

// File: rtl/ivc_buf.sv
// Two-entry valid/ready buffer; the head entry drives the outputs.
// Assumes a single clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module ivc_buf #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	import ivc_pkg::*;
	logic tail_v_reg;
	logic [W-1:0] tail_reg;
	logic pop;
	logic push;

	assign pop = out_valid & out_ready;
	assign push = in_valid & in_ready;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			out_valid <= 1'b0;
			tail_v_reg <= 1'b0;
			in_ready <= 1'b0;
		end else begin
			if (pop || !out_valid) begin
				out_valid <= tail_v_reg | push;
				tail_v_reg <= tail_v_reg & push;
				in_ready <= ~(tail_v_reg & push);
			end else if (push) begin
				tail_v_reg <= 1'b1;
				in_ready <= 1'b0;
			end else begin
				in_ready <= ~tail_v_reg;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			out_data <= '0;
			tail_reg <= '0;
		end else begin
			if (pop || !out_valid) begin
				out_data <= tail_v_reg ? tail_reg : in_data;
				if (tail_v_reg && push) begin
					tail_reg <= in_data;
				end
			end else if (push) begin
				tail_reg <= in_data;
			end
		end
	end
endmodule : ivc_buf

// File: verification/ivc_classifier_props.sv
// Port-level checks for the ingress VLAN classifier.
// Assumes bind onto ivc_classifier; one clock, async active-low reset.
`timescale 1ns/1ps
module ivc_classifier_chk #(
	parameter int NPORT = 10,
	parameter int PW = 4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Frames
	input wire logic frm_valid,
	input wire logic frm_ready,
	input wire logic frm_tagged,
	input wire logic [ivc_pkg::VID_W-1:0] frm_tag_vid,
	// Results
	input wire logic cls_valid,
	input wire logic cls_ready,
	input wire logic [PW-1:0] cls_port,
	input wire logic [ivc_pkg::VID_W-1:0] cls_vid,
	input wire ivc_pkg::ivc_src_e cls_src,
	input wire logic [NPORT-1:0] cls_fwd_mask
);
	import ivc_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_pready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	chk_apb_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready) else $error("apb wait wrong");
	chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
	chk_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000) else $error("prdata not zero");
	chk_cls_first: assert property (frm_valid && frm_ready && !cls_valid |=> cls_valid) else $error("result late");
	chk_cls_hold: assert property (cls_valid && !cls_ready |=> cls_valid && $stable(cls_vid) && $stable(cls_src)
		&& $stable(cls_fwd_mask) && $stable(cls_port)) else $error("result changed while stalled");
	chk_tag_keep: assert property (frm_valid && frm_ready && frm_tagged && !cls_valid |=>
		cls_src == IVC_SRC_TAG && cls_vid == $past(frm_tag_vid)) else $error("tagged vid lost");
	chk_no_self: assert property (cls_valid |-> !cls_fwd_mask[cls_port]) else $error("source in mask");
	chk_full_hold: assert property (cls_valid && !cls_ready && !frm_ready |=> !frm_ready) else $error("full lost");
	cov_refused: cover property (pready && pslverr);
	cov_mac: cover property (cls_valid && cls_src == IVC_SRC_MAC);
	cov_full: cover property (!frm_ready && cls_valid && !cls_ready);
endmodule : ivc_classifier_chk

bind ivc_classifier ivc_classifier_chk #(.NPORT(NPORT), .PW(PW)) chk_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.frm_valid(frm_valid), .frm_ready(frm_ready), .frm_tagged(frm_tagged), .frm_tag_vid(frm_tag_vid),
	.cls_valid(cls_valid), .cls_ready(cls_ready), .cls_port(cls_port), .cls_vid(cls_vid),
	.cls_src(cls_src), .cls_fwd_mask(cls_fwd_mask));

// File: verification/ivc_far.sv
// Forwarding-engine model: drains results, prompt, slow or stalled.
// Assumes pclk domain; taken results are queued for the bench.
`timescale 1ns/1ps
module ivc_far #(
	parameter int NPORT = 10,
	parameter int PW = 4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pace control
	input wire logic stall,
	input wire logic slow,
	// Results
	input wire logic cls_valid,
	output logic cls_ready,
	input wire logic [PW-1:0] cls_port,
	input wire logic [ivc_pkg::VID_W-1:0] cls_vid,
	input wire ivc_pkg::ivc_src_e cls_src,
	input wire logic [NPORT-1:0] cls_fwd_mask
);
	import ivc_pkg::*;
	logic [28:0] got[$];
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cls_ready <= 1'b0;
		end else begin
			cls_ready <= !stall && (!slow || !cls_ready);
			if (cls_valid && cls_ready) begin
				got.push_back({cls_port, cls_vid, cls_src, cls_fwd_mask});
			end
		end
	end
endmodule : ivc_far

// File: verification/tb.sv
// Self-checking bench for the ingress VLAN classifier.
// Assumes default sizes; APB master and frame source live here.
`timescale 1ns/1ps
module tb;
	import ivc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, frm_sip = 0;
	logic frm_valid = 0, frm_ready, frm_tagged = 0, frm_ip_valid = 0, cls_valid, cls_ready, stall = 0, slow = 0;
	logic [3:0] frm_port = 0, cls_port;
	logic [11:0] frm_tag_vid = 0, cls_vid;
	logic [47:0] frm_smac = 0;
	ivc_fmt_e frm_fmt = IVC_FMT_ETH;
	logic [15:0] frm_type = 0;
	logic [23:0] frm_oui = 0;
	ivc_src_e cls_src;
	logic [9:0] cls_fwd_mask;
	logic [28:0] exp_q[$];
	int bad_count = 0, checked = 0, cyc = 0;
	always #5 pclk = ~pclk;
	ivc_classifier uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.frm_valid(frm_valid), .frm_ready(frm_ready), .frm_port(frm_port), .frm_tagged(frm_tagged),
		.frm_tag_vid(frm_tag_vid), .frm_smac(frm_smac), .frm_fmt(frm_fmt), .frm_type(frm_type),
		.frm_oui(frm_oui), .frm_ip_valid(frm_ip_valid), .frm_sip(frm_sip), .cls_valid(cls_valid),
		.cls_ready(cls_ready), .cls_port(cls_port), .cls_vid(cls_vid), .cls_src(cls_src),
		.cls_fwd_mask(cls_fwd_mask));
	ivc_far far (.pclk(pclk), .presetn(presetn), .stall(stall), .slow(slow), .cls_valid(cls_valid),
		.cls_ready(cls_ready), .cls_port(cls_port), .cls_vid(cls_vid), .cls_src(cls_src),
		.cls_fwd_mask(cls_fwd_mask));
	task automatic tally_and_finish;
		if (bad_count == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : tally_and_finish
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		if (!w) chk($sformatf("read %h", a), d, prdata);
		chk($sformatf("pslverr %h", a), {31'b0, err}, {31'b0, pslverr});
	endtask : apb
	task automatic fr(input logic [3:0] p, input logic tg, input logic [47:0] mac, input ivc_fmt_e f,
		input logic [15:0] ty, input logic [23:0] ou, input logic [31:0] ip, input logic [11:0] ev,
		input ivc_src_e es, input logic [9:0] em);
		@(posedge pclk);
		frm_valid <= 1'b1;
		frm_port <= p;
		frm_tagged <= tg;
		frm_tag_vid <= 12'h123;
		frm_smac <= mac;
		frm_fmt <= f;
		frm_type <= ty;
		frm_oui <= ou;
		frm_ip_valid <= (ip != 0);
		frm_sip <= ip;
		do @(posedge pclk); while (frm_ready !== 1'b1);
		frm_valid <= 1'b0;
		exp_q.push_back({p, ev, es, em});
	endtask : fr
	task automatic drain;
		while (far.got.size() != exp_q.size()) @(posedge pclk);
		while (exp_q.size() > 0) chk("result", {3'b0, exp_q.pop_front()}, {3'b0, far.got.pop_front()});
	endtask : drain
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 12'h010, 32'h0000_0000, 0);
		apb(0, 12'h000, 32'h0000_0007, 0);
		apb(0, 12'h130, 32'h0000_0001, 0);
		apb(0, 12'h530, 32'h0000_0800, 0);
		apb(0, 12'hf00, 32'h0000_0000, 1);
		apb(1, 12'h020, 32'h0000_0005, 1);
		apb(1, 12'h300, 32'h8000_0001, 0);
		apb(1, 12'h304, 32'h0000_03ff, 0);
		apb(1, 12'h408, 32'h0000_0002, 0);
		apb(1, 12'h400, 32'h2233_4455, 0);
		apb(1, 12'h404, 32'h8005_0011, 0);
		apb(1, 12'h410, 32'h2233_4455, 0);
		apb(1, 12'h414, 32'h8007_0011, 1);
		apb(1, 12'h620, 32'h8000_0006, 0);
		apb(1, 12'h508, 32'h0000_03ff, 0);
		apb(1, 12'h500, 32'h8302_88b5, 1);
		apb(1, 12'h500, 32'h8002_05ff, 1);
		apb(1, 12'h500, 32'h8002_88b5, 0);
		apb(1, 12'h518, 32'h0000_03ff, 0);
		apb(1, 12'h514, 32'h0000_0000, 0);
		apb(1, 12'h510, 32'h8102_0100, 1);
		apb(1, 12'h514, 32'h00a0_b0c0, 0);
		apb(1, 12'h510, 32'h8102_0001, 0);
		apb(1, 12'h528, 32'h0000_03ff, 0);
		apb(1, 12'h520, 32'h8202_4242, 0);
		apb(1, 12'h540, 32'h0200_0000, 0);
		apb(0, 12'h540, 32'h0200_ffff, 0);
		apb(1, 12'h708, 32'h0000_03ff, 0);
		apb(1, 12'h700, 32'h0a01_0000, 0);
		apb(1, 12'h704, 32'h8021_0009, 1);
		apb(1, 12'h704, 32'h8010_0009, 0);
		fr(1, 0, 48'h0011_2233_4455, IVC_FMT_ETH, 16'h0800, 0, 0, 12'h005, IVC_SRC_MAC, 0);
		fr(2, 0, 48'h0011_2233_4455, IVC_FMT_ETH, 16'h0800, 0, 0, 12'h001, IVC_SRC_DEFAULT, 10'h3fb);
		fr(1, 1, 48'h0011_2233_4455, IVC_FMT_ETH, 16'h0800, 0, 0, 12'h123, IVC_SRC_TAG, 0);
		fr(3, 0, 0, IVC_FMT_ETH, 16'h88b5, 0, 0, 12'h006, IVC_SRC_PROTO, 0);
		fr(3, 0, 0, IVC_FMT_SNAP, 16'h0001, 24'ha0b0c0, 0, 12'h006, IVC_SRC_PROTO, 0);
		fr(3, 0, 0, IVC_FMT_LLC, 16'h4242, 0, 0, 12'h006, IVC_SRC_PROTO, 0);
		fr(4, 0, 0, IVC_FMT_ETH, 16'h0800, 0, 32'h0a01_ffee, 12'h009, IVC_SRC_SUBNET, 0);
		fr(4, 0, 0, IVC_FMT_ETH, 16'h0800, 0, 32'h0a02_0001, 12'h001, IVC_SRC_DEFAULT, 10'h3ef);
		drain();
		stall <= 1'b1;
		fr(0, 0, 0, IVC_FMT_ETH, 16'h0800, 0, 0, 12'h001, IVC_SRC_DEFAULT, 10'h3fe);
		fr(0, 0, 0, IVC_FMT_ETH, 16'h0800, 0, 0, 12'h001, IVC_SRC_DEFAULT, 10'h3fe);
		repeat (2) @(posedge pclk);
		chk("frm_ready", 32'h0000_0000, {31'b0, frm_ready});
		stall <= 1'b0;
		slow <= 1'b1;
		drain();
		apb(0, 12'h020, 32'h0000_000a, 0);
		apb(1, 12'h010, 32'h0000_000f, 0);
		apb(0, 12'h010, 32'h0000_000f, 0);
		fr(0, 0, 0, IVC_FMT_ETH, 16'h0800, 0, 0, 12'h001, IVC_SRC_DEFAULT, 10'h3f0);
		fr(5, 0, 0, IVC_FMT_ETH, 16'h0800, 0, 0, 12'h001, IVC_SRC_DEFAULT, 10'h3df);
		apb(1, 12'h200, 32'h0000_00ff, 0);
		fr(5, 0, 0, IVC_FMT_ETH, 16'h0800, 0, 0, 12'h001, IVC_SRC_DEFAULT, 10'h0df);
		fr(9, 0, 0, IVC_FMT_ETH, 16'h0800, 0, 0, 12'h001, IVC_SRC_DEFAULT, 10'h000);
		apb(1, 12'h000, 32'h0000_0000, 0);
		fr(4, 0, 0, IVC_FMT_ETH, 16'h0800, 0, 32'h0a01_ffee, 12'h001, IVC_SRC_DEFAULT, 10'h0ef);
		drain();
		tally_and_finish();
	end
endmodule : tb
